// [verilog/fdp_pkg.sv]
// constants for the fieldbus drive parameter bank
package fdp_pkg;
    // ------------------------------------------------------------
    // parameter addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_SCALE_DEN = 16'h060E;
    localparam logic [15:0] ADDR_SCALE_NUM = 16'h0610;
    localparam logic [15:0] ADDR_DIR       = 16'h0618;
    localparam logic [15:0] ADDR_OUT_MAP   = 16'h1804;
    localparam logic [15:0] ADDR_IN_MAP    = 16'h1806;
    localparam logic [15:0] ADDR_WAIT      = 16'h1808;
    localparam logic [15:0] ADDR_SAFE      = 16'h180A;
    localparam logic [15:0] ADDR_IN5_MAP   = 16'h181E;
    localparam logic [15:0] ADDR_PP_SPEED  = 16'h230A;
    localparam logic [15:0] ADDR_ABS_TGT   = 16'h230C;
    // ------------------------------------------------------------
    // mappable sources (drive to master) and targets
    // ------------------------------------------------------------
    localparam logic [31:0] SRC_ERR   = 32'h0000_1C0A; // last error
    localparam logic [31:0] SRC_DIO   = 32'h0000_0802; // digital i/o
    localparam logic [31:0] SRC_TEMP  = 32'h0000_1C20; // stage temp
    localparam logic [31:0] SRC_DCBUS = 32'h0000_1C1E; // dc bus
    localparam logic [31:0] SRC_CURR  = 32'h0000_1E28; // motor current
    localparam logic [31:0] SRC_ACT   = 32'h0000_1C08; // action word
    localparam logic [31:0] TGT_ACC   = 32'h0000_0614; // acceleration
    localparam logic [31:0] TGT_DEC   = 32'h0000_0616; // deceleration
    localparam logic [31:0] TGT_SYM   = 32'h0000_0602; // symm. ramp
    // ------------------------------------------------------------
    // reset values and legal ranges
    // ------------------------------------------------------------
    localparam logic [31:0] RST_DEN    = 32'h0000_4000;
    localparam logic [31:0] RST_NUM    = 32'h0000_0001;
    localparam logic [15:0] RST_DIR    = 16'h0000;
    localparam logic [31:0] RST_MAP    = 32'h0000_0000;
    localparam logic [15:0] RST_WAIT   = 16'h03E8;
    localparam logic [15:0] RST_SAFE   = 16'h0000;
    localparam logic [15:0] RST_SPEED  = 16'h003C;
    localparam logic [31:0] RST_TGT    = 32'h0000_0000;
    localparam logic [31:0] MAP_MAX    = 32'h0000_FFFF;
    localparam logic [15:0] BIT_MAX    = 16'h0001;
    localparam logic [31:0] SCALE_MIN  = 32'h0000_0001;
    localparam logic [31:0] SCALE_MAX  = 32'h7FFF_FFFF;
    localparam logic [15:0] SPEED_MIN  = 16'h0001;
    localparam logic [15:0] SPEED_MAX  = 16'h0BB8;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
endpackage : fdp_pkg

// [verilog/fdp_sync2.sv]
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module fdp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys, // system clock
    input  wire logic         rst_b,   // async reset, low
    input  wire logic         clk_en,  // freezes state
    input  wire logic [W-1:0] d_pin,   // asynchronous level
    output logic      [W-1:0] q_sync   // synchronised level
);
    logic [W-1:0] meta_reg; // first stage, read only by q_sync

    // ------------------------------------------------------------
    // two stages, nothing else looks at the first
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= '0;
            q_sync   <= '0;
        end
        else if (clk_en)
        begin
            meta_reg <= d_pin;
            q_sync   <= meta_reg;
        end
    end
endmodule : fdp_sync2

// [verilog/fdp_param_bank.sv]
// fieldbus drive parameter bank: mapping, scaling, safe state
`timescale 1ns/1ns
module fdp_param_bank
    import fdp_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS // shorten in simulation
) (
    input  wire logic        clk_sys,         // 100 MHz clock
    input  wire logic        rst_b,           // async reset, low
    input  wire logic        clk_en,          // freezes all state
    input  wire logic        param_req,       // access strobe
    input  wire logic        param_we,        // 1 write, 0 read
    input  wire logic [15:0] param_addr,      // parameter address
    input  wire logic [31:0] param_wdata,     // write value
    output logic             param_ack,       // answer pulse
    output logic             param_err,       // refused access
    output logic      [31:0] param_rdata,     // read value
    input  wire logic [31:0] src_last_error,  // drive status
    input  wire logic [31:0] src_digital_io,  // drive status
    input  wire logic [31:0] src_stage_temp,  // drive status
    input  wire logic [31:0] src_dc_bus,      // drive status
    input  wire logic [31:0] src_motor_curr,  // drive status
    input  wire logic [31:0] src_action_word, // drive status
    output logic      [15:0] pzd5_to_master,  // inbound word 5
    output logic      [15:0] pzd6_to_master,  // inbound word 6
    input  wire logic        pzd_out_valid,   // new outbound data
    input  wire logic [15:0] pzd5_from_master,// outbound word 5
    input  wire logic [15:0] pzd6_from_master,// outbound word 6
    output logic             map_wr_strobe,   // mapped write pulse
    output logic      [15:0] map_wr_addr,     // mapped target
    output logic      [31:0] map_wr_data,     // mapped value
    input  wire logic        read_task_active,// static read task
    output logic             read_refresh,    // refresh pulse
    input  wire logic        master_clear_pin,// master in clear
    input  wire logic        watchdog_pin,    // watchdog expired
    input  wire logic        power_stage_on,  // stage enabled
    output logic             class_two_error, // error pulse
    output logic             fault_request,   // go to fault pulse
    output logic             dir_ccw,         // 1 counter-clockwise
    output logic      [31:0] scale_num_active,// active numerator
    output logic      [31:0] scale_den_active,// active denominator
    input  wire logic [15:0] max_speed_limit, // maximum speed
    output logic      [15:0] speed_ref_limited,// capped speed
    input  wire logic [31:0] target_min,      // lower user bound
    input  wire logic [31:0] target_max,      // upper user bound
    output logic      [31:0] target_position  // absolute target
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [31:0] den_reg;     // written denominator
    logic [31:0] num_reg;     // written numerator
    logic [15:0] dir_reg;     // rotation direction
    logic [31:0] out_map_reg; // outbound selector
    logic [31:0] in_map_reg;  // inbound selector
    logic [31:0] in5_map_reg; // word-5 selector
    logic [15:0] wait_reg;    // read task wait, ms
    logic [15:0] safe_reg;    // safe state response
    logic [15:0] speed_reg;   // profile speed
    logic [31:0] tgt_reg;     // absolute target
    logic [31:0] ms_pre_reg;  // cycles within a ms
    logic [15:0] ms_cnt_reg;  // elapsed ms
    logic        ev_prev_reg; // last safe event level
    logic [1:0]  ev_sync;     // synced clear, watchdog

    // ------------------------------------------------------------
    // source selection and legality
    // ------------------------------------------------------------
    function automatic logic is_src(input logic [31:0] a);
        is_src = (a == SRC_ERR) || (a == SRC_DIO)
              || (a == SRC_TEMP) || (a == SRC_DCBUS)
              || (a == SRC_CURR) || (a == SRC_ACT);
    endfunction : is_src

    function automatic logic [31:0] pick(
        input logic [31:0] a,
        input logic [31:0] e, d, t, b, c, w);
        pick = (a == SRC_ERR)   ? e :
               (a == SRC_DIO)   ? d :
               (a == SRC_TEMP)  ? t :
               (a == SRC_DCBUS) ? b :
               (a == SRC_CURR)  ? c :
               (a == SRC_ACT)   ? w : '0;
    endfunction : pick

    wire [31:0] in_val  = pick(in_map_reg, src_last_error,
        src_digital_io, src_stage_temp, src_dc_bus,
        src_motor_curr, src_action_word);
    wire [31:0] in5_val = pick(in5_map_reg, src_last_error,
        src_digital_io, src_stage_temp, src_dc_bus,
        src_motor_curr, src_action_word);
    // motor current is the only 32-bit source
    wire in_is16 = is_src(in_map_reg) && (in_map_reg != SRC_CURR);

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    wire hit_den   = param_addr == ADDR_SCALE_DEN;
    wire hit_num   = param_addr == ADDR_SCALE_NUM;
    wire hit_dir   = param_addr == ADDR_DIR;
    wire hit_out   = param_addr == ADDR_OUT_MAP;
    wire hit_in    = param_addr == ADDR_IN_MAP;
    wire hit_wait  = param_addr == ADDR_WAIT;
    wire hit_safe  = param_addr == ADDR_SAFE;
    wire hit_in5   = param_addr == ADDR_IN5_MAP;
    wire hit_speed = param_addr == ADDR_PP_SPEED;
    wire hit_tgt   = param_addr == ADDR_ABS_TGT;
    wire hit_any   = hit_den | hit_num | hit_dir | hit_out
                   | hit_in | hit_wait | hit_safe | hit_in5
                   | hit_speed | hit_tgt;
    wire [15:0] wlo = param_wdata[15:0];
    wire hi_zero    = param_wdata[31:16] == 16'h0000;
    // value checks; den and num share one, dir and safe share one
    wire ok_scale = (param_wdata >= SCALE_MIN)
                 && (param_wdata <= SCALE_MAX);
    wire ok_bit   = hi_zero && (wlo <= BIT_MAX);
    wire ok_out   = (param_wdata <= MAP_MAX)
                 && ((param_wdata == RST_MAP)
                 || (param_wdata == TGT_ACC)
                 || (param_wdata == TGT_DEC)
                 || (param_wdata == TGT_SYM));
    wire ok_in    = (param_wdata == RST_MAP)
                 || is_src(param_wdata);
    // word 5 only beside a 16-bit primary, and only 16-bit itself
    wire ok_in5   = in_is16 && ((param_wdata == RST_MAP)
                 || (is_src(param_wdata)
                 && (param_wdata != SRC_CURR)));
    wire ok_speed = hi_zero && (wlo >= SPEED_MIN)
                 && (wlo <= SPEED_MAX);
    wire ok_tgt   = ($signed(param_wdata) >= $signed(target_min))
                 && ($signed(param_wdata) <= $signed(target_max));
    wire val_ok   = hit_den   ? ok_scale :
                    hit_num   ? ok_scale :
                    (hit_dir | hit_safe) ? ok_bit :
                    hit_out   ? ok_out :
                    hit_in    ? ok_in :
                    hit_wait  ? hi_zero :
                    hit_in5   ? ok_in5 :
                    hit_speed ? ok_speed :
                    hit_tgt   ? ok_tgt : 1'b0;
    wire wr_ok    = param_req && param_we && val_ok;
    wire [31:0] rd_mux =
        hit_den   ? den_reg :
        hit_num   ? num_reg :
        hit_dir   ? {16'h0000, dir_reg} :
        hit_out   ? out_map_reg :
        hit_in    ? in_map_reg :
        hit_wait  ? {16'h0000, wait_reg} :
        hit_safe  ? {16'h0000, safe_reg} :
        hit_in5   ? in5_map_reg :
        hit_speed ? {16'h0000, speed_reg} :
        hit_tgt   ? tgt_reg : 32'h0000_0000;

    // ------------------------------------------------------------
    // parameter storage, only legal values land
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            den_reg     <= RST_DEN;
            num_reg     <= RST_NUM;
            dir_reg     <= RST_DIR;
            out_map_reg <= RST_MAP;
            in_map_reg  <= RST_MAP;
            in5_map_reg <= RST_MAP;
            wait_reg    <= RST_WAIT;
            safe_reg    <= RST_SAFE;
            speed_reg   <= RST_SPEED;
            tgt_reg     <= RST_TGT;
        end
        else if (clk_en && wr_ok)
        begin
            if (hit_den)   den_reg     <= param_wdata;
            if (hit_num)   num_reg     <= param_wdata;
            if (hit_dir)   dir_reg     <= wlo;
            if (hit_out)   out_map_reg <= param_wdata;
            if (hit_in)    in_map_reg  <= param_wdata;
            if (hit_in5)   in5_map_reg <= param_wdata;
            if (hit_wait)  wait_reg    <= wlo;
            if (hit_safe)  safe_reg    <= wlo;
            if (hit_speed) speed_reg   <= wlo;
            if (hit_tgt)   tgt_reg     <= param_wdata;
        end
    end

    // ------------------------------------------------------------
    // access answer, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            param_ack   <= 1'b0;
            param_err   <= 1'b0;
            param_rdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            param_ack   <= param_req;
            // unknown address or illegal value both refuse
            param_err   <= param_req
                        && (!hit_any || (param_we && !val_ok));
            param_rdata <= (param_req && !param_we) ? rd_mux
                                                    : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // active scaling: the numerator write commits the pair
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scale_num_active <= RST_NUM;
            scale_den_active <= RST_DEN;
        end
        else if (clk_en && wr_ok && hit_num)
        begin
            scale_num_active <= param_wdata;
            scale_den_active <= den_reg;
        end
    end

    // ------------------------------------------------------------
    // process data in both directions
    // ------------------------------------------------------------
    wire out_on = out_map_reg != RST_MAP;
    wire in5_on = in5_map_reg != RST_MAP;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pzd5_to_master <= 16'h0000;
            pzd6_to_master <= 16'h0000;
            map_wr_strobe  <= 1'b0;
            map_wr_addr    <= 16'h0000;
            map_wr_data    <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            // word 5 overridden by the 16-bit selector
            pzd5_to_master <= in5_on ? in5_val[15:0]
                                     : in_val[31:16];
            pzd6_to_master <= in_val[15:0];
            map_wr_strobe  <= pzd_out_valid && out_on;
            map_wr_addr    <= out_map_reg[15:0];
            map_wr_data    <= {pzd5_from_master,
                               pzd6_from_master};
        end
    end

    // ------------------------------------------------------------
    // read task refresh timer
    // ------------------------------------------------------------
    wire ms_tick  = ms_pre_reg == 32'(MS_CYCLES - 1);
    wire wait_end = ms_tick
                 && (ms_cnt_reg == wait_reg - 16'h0001);
    wire fire     = read_task_active
                 && ((wait_reg == RST_DIR) || wait_end);
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ms_pre_reg   <= 32'h0000_0000;
            ms_cnt_reg   <= 16'h0000;
            read_refresh <= 1'b0;
        end
        else if (clk_en)
        begin
            read_refresh <= fire;
            if (!read_task_active || fire)
            begin
                // idle or period done: start a fresh period
                ms_pre_reg <= 32'h0000_0000;
                ms_cnt_reg <= 16'h0000;
            end
            else if (ms_tick)
            begin
                ms_pre_reg <= 32'h0000_0000;
                ms_cnt_reg <= ms_cnt_reg + 16'h0001;
            end
            else
                ms_pre_reg <= ms_pre_reg + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // safe state on master clear or watchdog expiry
    // ------------------------------------------------------------
    fdp_sync2 #(.W(2)) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .d_pin   ({master_clear_pin, watchdog_pin}),
        .q_sync  (ev_sync)
    );
    wire ev_now  = |ev_sync;
    wire ev_rise = ev_now && !ev_prev_reg;
    wire ss_err  = safe_reg[0];
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ev_prev_reg     <= 1'b0;
            class_two_error <= 1'b0;
            fault_request   <= 1'b0;
        end
        else if (clk_en)
        begin
            ev_prev_reg     <= ev_now;
            class_two_error <= ev_rise && ss_err;
            fault_request   <= ev_rise && ss_err
                            && power_stage_on;
        end
    end

    // ------------------------------------------------------------
    // direction and capped profile speed
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dir_ccw           <= 1'b0;
            speed_ref_limited <= RST_SPEED;
            target_position   <= RST_TGT;
        end
        else if (clk_en)
        begin
            dir_ccw           <= dir_reg[0];
            speed_ref_limited <= (speed_reg > max_speed_limit)
                               ? max_speed_limit
                               : speed_reg;
            target_position   <= tgt_reg;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_bad_speed_kept: assert property (
        clk_en && param_req && param_we && hit_speed && !ok_speed
        |=> param_err && speed_reg == $past(speed_reg))
        else $error("illegal speed write was stored");
    a_den_no_effect: assert property (
        clk_en && wr_ok && hit_den
        |=> scale_den_active == $past(scale_den_active))
        else $error("denominator changed active scaling");
    a_num_commits: assert property (
        clk_en && wr_ok && hit_num
        |=> scale_num_active == $past(param_wdata)
            && scale_den_active == $past(den_reg))
        else $error("numerator write did not commit");
    a_safe_off_quiet: assert property (
        clk_en && safe_reg == RST_SAFE |=> !class_two_error)
        else $error("error raised with no safe response");
    a_fault_with_err: assert property (
        fault_request |-> class_two_error)
        else $error("fault request without class two error");
    a_in5_gated: assert property (
        clk_en && param_req && param_we && hit_in5 && !in_is16
        |=> param_err && in5_map_reg == $past(in5_map_reg))
        else $error("word 5 map taken beside 32-bit map");
    a_in_map_legal: assert property (
        in_map_reg == RST_MAP || is_src(in_map_reg))
        else $error("inbound map holds illegal source");
    a_speed_capped: assert property (
        clk_en ##1 clk_en |-> speed_ref_limited <= $past(speed_reg)
            && speed_ref_limited <= $past(max_speed_limit))
        else $error("speed exceeds cap");
    a_zero_wait: assert property (
        clk_en && read_task_active && wait_reg == RST_DIR
        |=> read_refresh)
        else $error("zero wait did not refresh");
    a_map_write: assert property (
        clk_en && pzd_out_valid && out_on |=> map_wr_strobe
            && map_wr_data == {$past(pzd5_from_master),
                               $past(pzd6_from_master)})
        else $error("outbound mapping lost");
    c_num_commit: cover property (clk_en && wr_ok && hit_num);
    c_class_two:  cover property (class_two_error);
    c_refresh:    cover property (read_refresh && wait_reg != 0);
    c_word5:      cover property (clk_en && wr_ok && hit_in5);
endmodule : fdp_param_bank

// [verification/fdp_master_model.sv]
// fieldbus master model issuing parameter accesses
`timescale 1ns/1ns
module fdp_master_model (
    input  wire logic        clk_sys,     // system clock
    input  wire logic        param_ack,   // answer pulse
    input  wire logic        param_err,   // refusal flag
    input  wire logic [31:0] param_rdata, // read value
    output logic             param_req,   // access strobe
    output logic             param_we,    // write select
    output logic      [15:0] param_addr,  // address
    output logic      [31:0] param_wdata  // write value
);
    initial
        param_req = 1'b0;
    // one access: strobe for one cycle, wait bounded for the answer
    task automatic access(input logic w, input logic [15:0] a,
        input logic [31:0] d, output logic e, output logic [31:0] q);
        int n;
        @(negedge clk_sys);
        {param_req, param_we, param_addr, param_wdata} = {1'b1, w, a, d};
        @(negedge clk_sys);
        // released lines show junk, never the old value
        {param_req, param_addr, param_wdata} = {1'b0, ~a, ~d};
        for (n = 0; n < 4 && param_ack !== 1'b1; n++)
            @(negedge clk_sys);
        e = (n < 4) ? param_err : 1'bx;
        q = param_rdata;
    endtask : access
endmodule : fdp_master_model

// [verification/fdp_param_bank_test.sv]
// self-checking bench for the drive parameter bank
`timescale 1ns/1ns
module fdp_param_bank_test;
    import fdp_pkg::*;
    // ----------------------------------------
    // signals, held values and counters
    // ----------------------------------------
    logic clk_sys = 0, rst_b = 0, clk_en = 1, pzd_out_valid = 0, e;
    logic read_task_active = 0, master_clear_pin = 0, watchdog_pin = 0;
    logic power_stage_on = 1, param_req, param_we, param_ack, param_err;
    logic map_wr_strobe, read_refresh, class_two_error, fault_request;
    logic dir_ccw;
    logic [15:0] param_addr, pzd5_to_master, pzd6_to_master, map_wr_addr;
    logic [15:0] pzd5_from_master = 16'h1234, pzd6_from_master = 16'h5678;
    logic [15:0] max_speed_limit = 16'h0064, speed_ref_limited;
    logic [31:0] param_wdata, param_rdata, map_wr_data, q, target_position;
    logic [31:0] scale_num_active, scale_den_active;
    logic [31:0] target_min = 32'hFFFF_FF00, target_max = 32'h0000_0100;
    logic [31:0] src_last_error = 32'h0E01, src_digital_io = 32'h0D10;
    logic [31:0] src_stage_temp = 32'h0C20, src_dc_bus = 32'h0B1E;
    logic [31:0] src_motor_curr = 32'hA5A5_0F28, src_action_word = 32'h0A08;
    int n_mismatch = 0, n_compared = 0, n;
    // ----------------------------------------
    // table: write, address, value, refusal, read value
    // ----------------------------------------
    typedef struct packed
    {logic w; logic [15:0] a; logic [31:0] d; logic r; logic [31:0] q;}
    fdp_row_t;
    localparam fdp_row_t ROWS [22] = '{
        '{0, ADDR_SCALE_DEN, 0, 0, RST_DEN},
        '{0, ADDR_SCALE_NUM, 0, 0, RST_NUM},
        '{0, ADDR_WAIT, 0, 0, RST_WAIT},
        '{0, ADDR_PP_SPEED, 0, 0, RST_SPEED},
        '{1, ADDR_PP_SPEED, 0, 1, 0},
        '{1, ADDR_PP_SPEED, 32'hBB9, 1, 0},
        '{1, ADDR_PP_SPEED, SPEED_MAX, 0, 0},
        '{0, ADDR_PP_SPEED, 0, 0, SPEED_MAX},
        '{1, ADDR_OUT_MAP, TGT_ACC, 0, 0},
        '{1, ADDR_OUT_MAP, 32'h5, 1, 0},
        '{1, ADDR_IN_MAP, SRC_CURR, 0, 0},
        '{1, ADDR_IN5_MAP, SRC_DIO, 1, 0},
        '{1, ADDR_IN_MAP, SRC_TEMP, 0, 0},
        '{1, ADDR_IN5_MAP, SRC_DIO, 0, 0},
        '{1, ADDR_DIR, 32'h1, 0, 0},
        '{1, ADDR_DIR, 32'h2, 1, 0},
        '{1, ADDR_SCALE_DEN, 32'h2, 0, 0},
        '{0, 16'h3000, 0, 1, 0},
        '{1, ADDR_SAFE, 32'h1, 0, 0},
        '{1, ADDR_WAIT, 32'h1, 0, 0},
        '{1, ADDR_ABS_TGT, 32'h101, 1, 0},
        '{1, ADDR_ABS_TGT, 32'hFFFF_FF00, 0, 0}};
    always #5 clk_sys = ~clk_sys;
    fdp_param_bank #(.MS_CYCLES(4)) DUT (.*);
    fdp_master_model u_mst (.*);
    task automatic chk(input logic [63:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) @(negedge clk_sys);
        rst_b = 1'b1;
        chk(target_position, RST_TGT);
        foreach (ROWS[i])
        begin
            u_mst.access(ROWS[i].w, ROWS[i].a, ROWS[i].d, e, q);
            chk(e, ROWS[i].r);
            chk(q, ROWS[i].q);
        end
        $display("table test done");
        chk(scale_den_active, RST_DEN);
        u_mst.access(1'b1, ADDR_SCALE_NUM, 32'h3, e, q);
        @(negedge clk_sys);
        chk({scale_num_active, scale_den_active}, 64'h3_0000_0002);
        chk({dir_ccw, speed_ref_limited}, 17'h1_0064);
        chk(target_position, 32'hFFFF_FF00);
        chk({pzd5_to_master, pzd6_to_master}, 32'h0D10_0C20);
        @(negedge clk_sys) pzd_out_valid = 1'b1;
        @(negedge clk_sys) pzd_out_valid = 1'b0;
        chk({map_wr_strobe, map_wr_addr}, 17'h1_0614);
        chk(map_wr_data, 32'h1234_5678);
        // word 5 free again: primary upper half shows through
        u_mst.access(1'b1, ADDR_IN5_MAP, RST_MAP, e, q);
        u_mst.access(1'b1, ADDR_IN_MAP, SRC_CURR, e, q);
        @(negedge clk_sys);
        chk({pzd5_to_master, pzd6_to_master}, 32'hA5A5_0F28);
        $display("mapping test done");
        watchdog_pin = 1'b1;
        for (n = 0; n < 8 && class_two_error !== 1'b1; n++)
            @(negedge clk_sys);
        chk({fault_request, n[3:0]}, 5'h13);
        read_task_active = 1'b1;
        for (n = 0; n < 20 && read_refresh !== 1'b1; n++)
            @(negedge clk_sys);
        chk(n, 4);
        for (n = 1; n < 20; n++)
        begin
            @(negedge clk_sys);
            if (read_refresh === 1'b1)
                break;
        end
        chk(n, 4);
        // zero wait: refresh on every cycle while the task runs
        u_mst.access(1'b1, ADDR_WAIT, 32'h0, e, q);
        @(negedge clk_sys);
        chk(read_refresh, 1'b1);
        $display("event test done");
        print_verdict();
    end
endmodule : fdp_param_bank_test
